// file: slcrc_pkg.sv
// shared constants and types for the strap latch and clock request control
package slcrc_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int NUM_SRC = 11;

  // register byte addresses
  localparam logic [7:0] ADDR_STATUS = 8'h00;
  localparam logic [7:0] ADDR_CFG5 = 8'h14;
  localparam logic [7:0] ADDR_CFG6 = 8'h18;

  // configuration byte reset values
  localparam logic [7:0] CFG5_RST = 8'h00;
  localparam logic [7:0] CFG6_RST = 8'h00;

  // configuration byte 5 fields
  localparam int B5_A_EN = 7;
  localparam int B5_A_SEL = 6;
  localparam int B5_B_EN = 5;
  localparam int B5_B_SEL = 4;
  // configuration byte 6 fields
  localparam int B6_E_EN = 7;
  localparam int B6_F_EN = 6;

  // serial-reference outputs steered by each request
  localparam int SRC_A_SEL0 = 0;
  localparam int SRC_A_SEL1 = 2;
  localparam int SRC_B_SEL0 = 1;
  localparam int SRC_B_SEL1 = 4;
  localparam int SRC_E = 6;
  localparam int SRC_F = 8;

  // status word fields
  localparam int ST_LATCHED = 0;
  localparam int ST_FS_LO = 1;
  localparam int ST_GFX = 4;
  localparam int ST_DBG = 5;
  localparam int ST_TME = 6;
  localparam int ST_TEST = 7;
  localparam int ST_PWRDN = 8;
  localparam int ST_MGMT = 9;

  // synchroniser depth for pin inputs
  localparam int SYNC_STAGES = 2;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic {
    SLCRC_WAIT_PG,
    SLCRC_LATCHED
  } slcrc_phase_t;

endpackage

// file: slcrc_sync2.sv
// two-flop synchroniser for a group of pin inputs
`timescale 1ns/1ps
module slcrc_sync2 #(
  parameter int WIDTH = 1
) (
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } slcrc_sync_t;

  slcrc_sync_t st_r;
  slcrc_sync_t st_nxt;

  // the first stage feeds only the second stage
  always_comb begin
    st_nxt.meta = async_i;
    st_nxt.stable = st_r.meta;
  end

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign sync_o = st_r.stable;

endmodule

// file: slcrc_axil_slave.sv
// AXI4-Lite slave front end: one write and one read at a time
`timescale 1ns/1ps
module slcrc_axil_slave (
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  input wire logic [slcrc_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [slcrc_pkg::DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [slcrc_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [slcrc_pkg::DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic wr_en_o,
  output logic [slcrc_pkg::ADDR_W-1:0] wr_addr_o,
  output logic [7:0] wr_byte_o,
  input wire logic wr_err_i,
  output logic [slcrc_pkg::ADDR_W-1:0] rd_addr_o,
  input wire logic [slcrc_pkg::DATA_W-1:0] rd_data_i,
  input wire logic rd_err_i
);

  typedef struct packed {
    logic aw_got;
    logic w_got;
    logic [slcrc_pkg::ADDR_W-1:0] awaddr;
    logic [7:0] wbyte;
    logic wlane;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [slcrc_pkg::DATA_W-1:0] rdata;
  } slcrc_axi_t;

  slcrc_axi_t st_r;
  slcrc_axi_t st_nxt;
  logic do_wr;

  assign s_axi_awready = !st_r.aw_got && !st_r.bvalid;
  assign s_axi_wready = !st_r.w_got && !st_r.bvalid;
  assign s_axi_arready = !st_r.rvalid;
  assign do_wr = st_r.aw_got && st_r.w_got && !st_r.bvalid;

  always_comb begin
    st_nxt = st_r;
    if (s_axi_awvalid && s_axi_awready) begin
      st_nxt.aw_got = 1'b1;
      st_nxt.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      st_nxt.w_got = 1'b1;
      st_nxt.wbyte = s_axi_wdata[7:0];
      st_nxt.wlane = s_axi_wstrb[0];
    end
    if (do_wr) begin
      st_nxt.aw_got = 1'b0;
      st_nxt.w_got = 1'b0;
      st_nxt.bvalid = 1'b1;
      st_nxt.bresp = wr_err_i ? slcrc_pkg::RESP_SLVERR : slcrc_pkg::RESP_OKAY;
    end
    if (st_r.bvalid && s_axi_bready) begin
      st_nxt.bvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      st_nxt.rvalid = 1'b1;
      st_nxt.rdata = rd_err_i ? '0 : rd_data_i;
      st_nxt.rresp = rd_err_i ? slcrc_pkg::RESP_SLVERR : slcrc_pkg::RESP_OKAY;
    end else if (st_r.rvalid && s_axi_rready) begin
      st_nxt.rvalid = 1'b0;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // a write with byte lane 0 off changes nothing but still answers
  assign wr_en_o = do_wr && st_r.wlane;
  assign wr_addr_o = st_r.awaddr;
  assign wr_byte_o = st_r.wbyte;
  assign rd_addr_o = s_axi_araddr;
  assign s_axi_bvalid = st_r.bvalid;
  assign s_axi_bresp = st_r.bresp;
  assign s_axi_rvalid = st_r.rvalid;
  assign s_axi_rresp = st_r.rresp;
  assign s_axi_rdata = st_r.rdata;

endmodule

// file: slcrc_top.sv
// strap latch, power-down pin and clock-request steering of a clock generator
`timescale 1ns/1ps
module slcrc_top (
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  input wire logic [slcrc_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [slcrc_pkg::DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [slcrc_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [slcrc_pkg::DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic power_good_strobe_i,
  input wire logic freq_strap_a_i,
  input wire logic freq_strap_b_i,
  input wire logic freq_strap_c_i,
  input wire logic graphics_clock_strap_i,
  input wire logic debug_port_clock_enable_strap_i,
  input wire logic trusted_mode_strap_i,
  input wire logic test_mode_strap_i,
  input wire logic test_mode_select_i,
  input wire logic clock_request_a_n_i,
  input wire logic clock_request_b_n_i,
  input wire logic clock_request_e_n_i,
  input wire logic clock_request_f_n_i,
  input wire logic mgmt_mode_active_i,
  output logic straps_latched_o,
  output logic [2:0] freq_strap_o,
  output logic graphics_clock_strap_o,
  output logic debug_port_clock_enable_strap_o,
  output logic trusted_mode_o,
  output logic overclock_allowed_o,
  output logic power_down_o,
  output logic shared_pair_cpu_o,
  output logic [slcrc_pkg::NUM_SRC-1:0] serial_ref_run_o,
  output logic processor_clock_one_run_o,
  output logic processor_clock_two_run_o,
  output logic pci_pin_a_clk_oe_o,
  output logic pci_pin_b_clk_oe_o,
  output logic src_pin_e_clk_oe_o,
  output logic src_pin_f_clk_oe_o,
  output logic outputs_tristate_o,
  output logic ref_div_n_o
);

  localparam int NPIN = 13;
  localparam int NSRC = slcrc_pkg::NUM_SRC;

  typedef struct packed {
    slcrc_pkg::slcrc_phase_t phase;
    logic [2:0] fs;
    logic gfx;
    logic dbg;
    logic trusted_mode_strap;
    logic test;
    logic [7:0] cfg5;
    logic [7:0] cfg6;
    logic pwrdn;
    logic processor_clock_one_run;
    logic processor_clock_two_run;
    logic [NSRC-1:0] src_run;
    logic tristate;
    logic refdiv;
  } slcrc_state_t;

  slcrc_state_t st_r;
  slcrc_state_t st_nxt;

  //////////////////////////////////////////////////////////////////////////////
  // pin synchronisers

  logic [NPIN-1:0] pin_s;
  logic pg_s;
  logic [2:0] fs_s;
  logic gfx_s;
  logic dbg_s;
  logic tme_s;
  logic test_s;
  logic tsel_s;
  logic req_a_n_s;
  logic req_b_n_s;
  logic req_e_n_s;
  logic req_f_n_s;
  logic mgmt_s;

  slcrc_sync2 #(
    .WIDTH(NPIN)
  ) u_sync (
    .core_clk_i(core_clk_i),
    .sys_rst_i(sys_rst_i),
    .async_i({power_good_strobe_i, freq_strap_c_i, freq_strap_b_i, freq_strap_a_i,
              graphics_clock_strap_i, debug_port_clock_enable_strap_i,
              trusted_mode_strap_i, test_mode_strap_i, test_mode_select_i,
              clock_request_a_n_i, clock_request_b_n_i, clock_request_e_n_i,
              clock_request_f_n_i}),
    .sync_o(pin_s)
  );

  assign {pg_s, fs_s, gfx_s, dbg_s, tme_s, test_s, tsel_s,
          req_a_n_s, req_b_n_s, req_e_n_s, req_f_n_s} = pin_s;

  // management mode comes from core logic on this clock
  assign mgmt_s = mgmt_mode_active_i;

  //////////////////////////////////////////////////////////////////////////////
  // register bus

  logic wr_en;
  logic [slcrc_pkg::ADDR_W-1:0] wr_addr;
  logic [7:0] wr_byte;
  logic wr_err;
  logic [slcrc_pkg::ADDR_W-1:0] rd_addr;
  logic [slcrc_pkg::DATA_W-1:0] rd_data;
  logic rd_err;

  function automatic logic addr_known(input logic [slcrc_pkg::ADDR_W-1:0] a);
    addr_known = (a == slcrc_pkg::ADDR_STATUS) || (a == slcrc_pkg::ADDR_CFG5) ||
                 (a == slcrc_pkg::ADDR_CFG6);
  endfunction

  slcrc_axil_slave u_axil (
    .core_clk_i(core_clk_i),
    .sys_rst_i(sys_rst_i),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .wr_en_o(wr_en),
    .wr_addr_o(wr_addr),
    .wr_byte_o(wr_byte),
    .wr_err_i(wr_err),
    .rd_addr_o(rd_addr),
    .rd_data_i(rd_data),
    .rd_err_i(rd_err)
  );

  // status is read-only, so a write to it is refused like an unmapped one
  assign wr_err = !addr_known(wr_addr) || (wr_addr == slcrc_pkg::ADDR_STATUS);
  assign rd_err = !addr_known(rd_addr);

  always_comb begin
    rd_data = '0;
    case (rd_addr)
      slcrc_pkg::ADDR_CFG5: rd_data[7:0] = st_r.cfg5;
      slcrc_pkg::ADDR_CFG6: rd_data[7:0] = st_r.cfg6;
      slcrc_pkg::ADDR_STATUS: begin
        rd_data[slcrc_pkg::ST_LATCHED] = (st_r.phase == slcrc_pkg::SLCRC_LATCHED);
        rd_data[slcrc_pkg::ST_FS_LO +: 3] = st_r.fs;
        rd_data[slcrc_pkg::ST_GFX] = st_r.gfx;
        rd_data[slcrc_pkg::ST_DBG] = st_r.dbg;
        rd_data[slcrc_pkg::ST_TME] = st_r.trusted_mode_strap;
        rd_data[slcrc_pkg::ST_TEST] = st_r.test;
        rd_data[slcrc_pkg::ST_PWRDN] = st_r.pwrdn;
        rd_data[slcrc_pkg::ST_MGMT] = mgmt_s;
      end
      default: rd_data = '0;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // strap latch, power-down and clock steering

  logic [NSRC-1:0] req_stop;
  logic running;

  // a request pin high (deasserted) asks its target output to stop
  always_comb begin
    req_stop = '0;
    if (st_r.cfg5[slcrc_pkg::B5_A_EN] && req_a_n_s) begin
      if (st_r.cfg5[slcrc_pkg::B5_A_SEL]) begin
        req_stop[slcrc_pkg::SRC_A_SEL1] = 1'b1;
      end else begin
        req_stop[slcrc_pkg::SRC_A_SEL0] = 1'b1;
      end
    end
    if (st_r.cfg5[slcrc_pkg::B5_B_EN] && req_b_n_s) begin
      if (st_r.cfg5[slcrc_pkg::B5_B_SEL]) begin
        req_stop[slcrc_pkg::SRC_B_SEL1] = 1'b1;
      end else begin
        req_stop[slcrc_pkg::SRC_B_SEL0] = 1'b1;
      end
    end
    if (st_r.cfg6[slcrc_pkg::B6_E_EN] && req_e_n_s) begin
      req_stop[slcrc_pkg::SRC_E] = 1'b1;
    end
    if (st_r.cfg6[slcrc_pkg::B6_F_EN] && req_f_n_s) begin
      req_stop[slcrc_pkg::SRC_F] = 1'b1;
    end
  end

  assign running = (st_r.phase == slcrc_pkg::SLCRC_LATCHED) && !st_r.pwrdn;

  always_comb begin
    st_nxt = st_r;
    case (st_r.phase)
      slcrc_pkg::SLCRC_WAIT_PG: begin
        // straps are captured on the first cycle the strobe is high, then freeze
        if (pg_s) begin
          st_nxt.fs = fs_s;
          st_nxt.gfx = gfx_s;
          st_nxt.dbg = dbg_s;
          st_nxt.trusted_mode_strap = tme_s;
          st_nxt.test = test_s;
          st_nxt.phase = slcrc_pkg::SLCRC_LATCHED;
        end
      end
      slcrc_pkg::SLCRC_LATCHED: begin
        // only reset leaves this state, so straps stay frozen
        st_nxt.pwrdn = !pg_s;
      end
      default: st_nxt.phase = slcrc_pkg::SLCRC_WAIT_PG;
    endcase
    if (wr_en && (wr_addr == slcrc_pkg::ADDR_CFG5)) begin
      st_nxt.cfg5 = wr_byte;
    end
    if (wr_en && (wr_addr == slcrc_pkg::ADDR_CFG6)) begin
      st_nxt.cfg6 = wr_byte;
    end
    st_nxt.src_run = running ? ~req_stop : '0;
    // the shared pair is SERIAL_REF_OUT_EIGHT only when the debug strap is 0
    if (st_r.dbg) begin
      st_nxt.src_run[slcrc_pkg::SRC_F] = 1'b0;
    end
    st_nxt.processor_clock_two_run = running && st_r.dbg;
    // power-down spares CPU clock 1 while management mode needs it
    st_nxt.processor_clock_one_run = running || mgmt_s;
    st_nxt.tristate = st_r.test && !tsel_s;
    st_nxt.refdiv = st_r.test && tsel_s;
  end

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      st_r <= '0;
      st_r.cfg5 <= slcrc_pkg::CFG5_RST;
      st_r.cfg6 <= slcrc_pkg::CFG6_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // outputs

  assign straps_latched_o = (st_r.phase == slcrc_pkg::SLCRC_LATCHED);
  assign freq_strap_o = st_r.fs;
  assign graphics_clock_strap_o = st_r.gfx;
  assign debug_port_clock_enable_strap_o = st_r.dbg;
  assign trusted_mode_o = st_r.trusted_mode_strap;
  assign overclock_allowed_o = straps_latched_o && !st_r.trusted_mode_strap;
  assign power_down_o = st_r.pwrdn;
  assign shared_pair_cpu_o = st_r.dbg;
  assign serial_ref_run_o = st_r.src_run;
  assign processor_clock_one_run_o = st_r.processor_clock_one_run;
  assign processor_clock_two_run_o = st_r.processor_clock_two_run;
  // a pin turned into a request input stops driving its clock
  assign pci_pin_a_clk_oe_o = !st_r.cfg5[slcrc_pkg::B5_A_EN];
  assign pci_pin_b_clk_oe_o = !st_r.cfg5[slcrc_pkg::B5_B_EN];
  assign src_pin_e_clk_oe_o = !st_r.cfg6[slcrc_pkg::B6_E_EN];
  assign src_pin_f_clk_oe_o = !st_r.cfg6[slcrc_pkg::B6_F_EN];
  assign outputs_tristate_o = st_r.tristate;
  assign ref_div_n_o = st_r.refdiv;

  //////////////////////////////////////////////////////////////////////////////
  // assertions

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (sys_rst_i);

  a_strap_capture: assert property (
    (st_r.phase == slcrc_pkg::SLCRC_WAIT_PG) && pg_s |=>
      straps_latched_o && (st_r.fs == $past(fs_s)) && (st_r.dbg == $past(dbg_s)))
    else $error("straps not captured on power-good");

  a_pwrdn_follow: assert property (
    straps_latched_o && $past(straps_latched_o) |-> power_down_o == !$past(pg_s))
    else $error("power-down does not follow the strobe pin");

  a_shared_pair: assert property (
    st_r.dbg |-> !serial_ref_run_o[slcrc_pkg::SRC_F]
      && (processor_clock_two_run_o == $past(running)))
    else $error("SERIAL_REF_OUT_EIGHT runs while pair carries CPU clock 2");

  a_processor_clock_two_sel: assert property (
    running && !st_r.dbg |=> !processor_clock_two_run_o)
    else $error("CPU clock 2 runs with debug strap 0");

  a_test_out: assert property (
    st_r.test && !tsel_s |=> outputs_tristate_o && !ref_div_n_o)
    else $error("test mode select 0 did not tri-state");

  a_pin_dir: assert property (
    wr_en && (wr_addr == slcrc_pkg::ADDR_CFG6) |=>
      src_pin_e_clk_oe_o == !$past(wr_byte[slcrc_pkg::B6_E_EN]))
    else $error("request E pin direction wrong");

  a_req_e_stop: assert property (
    running && st_r.cfg6[slcrc_pkg::B6_E_EN] && req_e_n_s && $stable(st_r.cfg6) |=>
      !serial_ref_run_o[slcrc_pkg::SRC_E])
    else $error("request E did not stop SERIAL_REF_OUT_SIX");

  a_req_a_target: assert property (
    running && st_r.cfg5[slcrc_pkg::B5_A_EN] && st_r.cfg5[slcrc_pkg::B5_A_SEL]
      && req_a_n_s |=>
      !serial_ref_run_o[slcrc_pkg::SRC_A_SEL1])
    else $error("request A did not stop SRC2");

  a_req_b_target: assert property (
    running && st_r.cfg5[slcrc_pkg::B5_B_EN] && !st_r.cfg5[slcrc_pkg::B5_B_SEL]
      && req_b_n_s && $stable(st_r.cfg5) |=> !serial_ref_run_o[slcrc_pkg::SRC_B_SEL0])
    else $error("request B did not stop SRC1");

  a_trusted_oc: assert property (
    trusted_mode_o |-> !overclock_allowed_o)
    else $error("overclocking allowed in trusted mode");

  a_mgmt_processor_clock_one: assert property (
    mgmt_s |=> processor_clock_one_run_o)
    else $error("CPU clock 1 stopped in management mode");

  a_straps_hold: assert property (
    straps_latched_o |=> straps_latched_o && $stable(st_r.fs) && $stable(st_r.gfx)
      && $stable(st_r.dbg) && $stable(st_r.trusted_mode_strap) && $stable(st_r.test))
    else $error("latched straps changed");

endmodule

// file: slcrc_chipset_model.sv
// chipset-side model driving the strobe, strap and clock-request pins
`timescale 1ns/1ps
module slcrc_chipset_model (
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  input wire logic pg_cmd_i,
  input wire logic [6:0] strap_cmd_i,
  input wire logic [3:0] req_n_cmd_i,
  output logic pg_pin_o,
  output logic [6:0] strap_pin_o,
  output logic [3:0] req_n_pin_o
);
  int hold_cnt;
  logic [6:0] pat_r;
  ////////////////////////////////////////////////////////////////////////////////
  // straps held a few cycles past the strobe so a synchronised capture still sees them
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      hold_cnt <= 0;
      pat_r <= 7'h00;
    end else begin
      pat_r <= ~pat_r;
      if (pg_cmd_i && hold_cnt < 8) begin
        hold_cnt <= hold_cnt + 1;
      end
    end
  end
  // afterwards the shared pins carry clocks, seen here as a toggling pattern
  assign strap_pin_o = (hold_cnt < 8) ? strap_cmd_i : pat_r;
  // one pin: strobe high to latch, then low requests power down
  assign pg_pin_o = pg_cmd_i;
  assign req_n_pin_o = req_n_cmd_i;
endmodule

// file: tb.sv
// self-checking bench for the strap latch and clock request control
`timescale 1ns/1ps
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin n_mismatch++; \
  $display("BAD %s exp %0h got %0h", nm, e, g); end end
module tb;
  int compares = 0;
  int n_mismatch = 0;
  logic core_clk_i = 1'h0;
  logic sys_rst_i = 1'h1;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic pg_cmd = 1'h0, test_mode_select_i = 1'h0, mgmt_mode_active_i = 1'h0;
  logic [6:0] strap_cmd = 7'h00, strap_pins;
  logic [3:0] req_cmd = 4'h0, req_pins;
  logic power_good_strobe_i, straps_latched_o, graphics_clock_strap_o;
  logic debug_port_clock_enable_strap_o, trusted_mode_o, overclock_allowed_o, power_down_o;
  logic shared_pair_cpu_o, processor_clock_one_run_o, processor_clock_two_run_o;
  logic pci_pin_a_clk_oe_o, pci_pin_b_clk_oe_o, src_pin_e_clk_oe_o, src_pin_f_clk_oe_o;
  logic outputs_tristate_o, ref_div_n_o;
  logic [2:0] freq_strap_o;
  logic [10:0] serial_ref_run_o;

  slcrc_chipset_model slcrc_chipset_model_inst (.core_clk_i, .sys_rst_i, .pg_cmd_i(pg_cmd),
    .strap_cmd_i(strap_cmd), .req_n_cmd_i(req_cmd), .pg_pin_o(power_good_strobe_i),
    .strap_pin_o(strap_pins), .req_n_pin_o(req_pins));

  slcrc_top slcrc_top_inst (.core_clk_i, .sys_rst_i, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .power_good_strobe_i,
    .freq_strap_a_i(strap_pins[0]), .freq_strap_b_i(strap_pins[1]),
    .freq_strap_c_i(strap_pins[2]), .graphics_clock_strap_i(strap_pins[3]),
    .debug_port_clock_enable_strap_i(strap_pins[4]), .trusted_mode_strap_i(strap_pins[5]),
    .test_mode_strap_i(strap_pins[6]), .test_mode_select_i,
    .clock_request_a_n_i(req_pins[0]), .clock_request_b_n_i(req_pins[1]),
    .clock_request_e_n_i(req_pins[2]), .clock_request_f_n_i(req_pins[3]),
    .mgmt_mode_active_i, .straps_latched_o, .freq_strap_o, .graphics_clock_strap_o,
    .debug_port_clock_enable_strap_o, .trusted_mode_o, .overclock_allowed_o, .power_down_o,
    .shared_pair_cpu_o, .serial_ref_run_o, .processor_clock_one_run_o,
    .processor_clock_two_run_o, .pci_pin_a_clk_oe_o, .pci_pin_b_clk_oe_o,
    .src_pin_e_clk_oe_o, .src_pin_f_clk_oe_o, .outputs_tristate_o, .ref_div_n_o);

  initial begin
    forever #2.5 core_clk_i = ~core_clk_i;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk_i);
  endtask

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(posedge core_clk_i);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'h0;
    @(posedge core_clk_i);
  endtask

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
      @(posedge core_clk_i);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'h0;
    @(posedge core_clk_i);
  endtask

  task automatic complete_run;
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // stopped when its request is enabled, aimed at it and the pin is high
  function automatic logic [10:0] exp_run(input logic [7:0] c5, c6, input logic [3:0] q);
    logic [10:0] v;
    v = 11'h7FF;
    if (c5[7]) v[c5[6] ? 2 : 0] = ~q[0];
    if (c5[5]) v[c5[4] ? 4 : 1] = ~q[1];
    if (c6[7]) v[6] = ~q[2];
    if (c6[6]) v[8] = ~q[3];
    return v;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (30000) @(posedge core_clk_i);
    n_mismatch++;
    complete_run();
  end

  initial begin
    logic [31:0] d;
    logic [1:0] r;
    logic [7:0] c5, c6;
    logic [6:0] st;
    logic [10:0] m;
    d = $urandom(32'h91DBD9D8);
    for (int p = 0; p < 2; p++) begin
      sys_rst_i <= 1'h1;
      pg_cmd <= 1'h0;
      req_cmd <= 4'h0;
      st = 7'($urandom());
      st[6] = p[0];
      strap_cmd <= st;
      test_mode_select_i <= 1'($urandom());
      tick(10);
      sys_rst_i <= 1'h0;
      mgmt_mode_active_i <= 1'h1;
      tick(5);
      `CHK("latched", 1'h0, straps_latched_o)
      `CHK("src_pre", 11'h000, serial_ref_run_o)
      `CHK("oe_a", 1'h1, pci_pin_a_clk_oe_o)
      `CHK("processor_clock_one_mgmt", 1'h1, processor_clock_one_run_o)
      axi_rd(slcrc_pkg::ADDR_CFG5, d, r);
      `CHK("cfg5_rst", 32'h0, d)
      mgmt_mode_active_i <= 1'h0;
      pg_cmd <= 1'h1;
      tick(8);
      for (int k = 0; k < 2; k++) begin
        `CHK("latched", 1'h1, straps_latched_o)
        `CHK("fs", st[2:0], freq_strap_o)
        `CHK("gfx", st[3], graphics_clock_strap_o)
        `CHK("dbg", st[4], debug_port_clock_enable_strap_o)
        `CHK("pair", st[4], shared_pair_cpu_o)
        `CHK("processor_clock_two", st[4], processor_clock_two_run_o)
        `CHK("processor_clock_one", 1'h1, processor_clock_one_run_o)
        `CHK("tme", st[5], trusted_mode_o)
        `CHK("oc", ~st[5], overclock_allowed_o)
        `CHK("tri", st[6] & ~test_mode_select_i, outputs_tristate_o)
        `CHK("refn", st[6] & test_mode_select_i, ref_div_n_o)
        test_mode_select_i <= ~test_mode_select_i;
        tick(6);
      end
      axi_rd(slcrc_pkg::ADDR_STATUS, d, r);
      `CHK("status", {22'h0, 2'h0, st, 1'h1}, d)
      // untargeted outputs must run too; the shared pair hides SERIAL_REF_OUT_EIGHT when the debug strap is 1
      m = st[4] ? 11'h6FF : 11'h7FF;
      for (int i = 0; i < 8; i++) begin
        c5 = {1'h1, i[0], 1'h1, i[1], 4'($urandom())};
        c6 = {i[2], ~i[2], 6'($urandom())};
        req_cmd <= 4'($urandom());
        axi_wr(slcrc_pkg::ADDR_CFG5, {24'($urandom()), c5}, r);
        `CHK("bresp", slcrc_pkg::RESP_OKAY, r)
        axi_wr(slcrc_pkg::ADDR_CFG6, {24'h0, c6}, r);
        tick(5);
        `CHK("oe_a", ~c5[7], pci_pin_a_clk_oe_o)
        `CHK("oe_b", ~c5[5], pci_pin_b_clk_oe_o)
        `CHK("oe_e", ~c6[7], src_pin_e_clk_oe_o)
        `CHK("oe_f", ~c6[6], src_pin_f_clk_oe_o)
        `CHK("src", exp_run(c5, c6, req_cmd) & m, serial_ref_run_o)
        axi_rd(slcrc_pkg::ADDR_CFG5, d, r);
        `CHK("cfg5", {24'h0, c5}, d)
      end
      pg_cmd <= 1'h0;
      tick(6);
      `CHK("pd", 1'h1, power_down_o)
      `CHK("src_pd", 11'h000, serial_ref_run_o)
      `CHK("processor_clock_two_pd", 1'h0, processor_clock_two_run_o)
      `CHK("processor_clock_one_pd", 1'h0, processor_clock_one_run_o)
      mgmt_mode_active_i <= 1'h1;
      tick(3);
      `CHK("processor_clock_one_mgmt", 1'h1, processor_clock_one_run_o)
      axi_rd(slcrc_pkg::ADDR_STATUS, d, r);
      `CHK("status_pd", {22'h0, 2'h3, st, 1'h1}, d)
      pg_cmd <= 1'h1;
      mgmt_mode_active_i <= 1'h0;
      tick(6);
      `CHK("pd_off", 1'h0, power_down_o)
      `CHK("fs_hold", st[2:0], freq_strap_o)
      axi_wr(slcrc_pkg::ADDR_STATUS, 32'h0, r);
      `CHK("ro_wr", slcrc_pkg::RESP_SLVERR, r)
      axi_rd(8'h40, d, r);
      `CHK("unmap", slcrc_pkg::RESP_SLVERR, r)
      `CHK("unmap_d", 32'h0, d)
    end
    complete_run();
  end
endmodule
